// ### vpw_map.svh
// register offsets, field positions, reset values and symbol timings of the vpw controller
`ifndef VPW_MAP_SVH
`define VPW_MAP_SVH

// apb byte offsets
`define VPW_OFF_CFG      8'h00
`define VPW_OFF_TX       8'h04
`define VPW_OFF_DLY      8'h08
`define VPW_OFF_RX       8'h0c
`define VPW_OFF_STAT     8'h10

// configuration fields
`define VPW_CFG_DIV_LO   0
`define VPW_CFG_DIV_HI   1
`define VPW_CFG_PLL      2
`define VPW_CFG_QUAD     3
`define VPW_CFG_EN       4
`define VPW_CFG_RST      5'h00
`define VPW_DLY_RST      8'h00

// transmit register fields
`define VPW_TX_LAST      8
`define VPW_TX_FULL      0
`define VPW_TX_BUSY      1

// status fields
`define VPW_ST_BE        0
`define VPW_ST_CRC       1
`define VPW_ST_TIM       2
`define VPW_ST_INC       3
`define VPW_ST_NOECHO    4
`define VPW_ST_LOST      5
`define VPW_ST_RXFULL    6
`define VPW_ST_BUS       7

// clock prescaler: reference rate and internal protocol clock per select code
`define VPW_REF_MHZ      8'hc8
`define VPW_INT_MHZ0     8'h04
`define VPW_INT_MHZ1     8'h06
`define VPW_INT_MHZ2     8'h08
`define VPW_INT_MHZ3     8'h0a

// symbol timings in microseconds at the normal bus rate
`define VPW_T_FILT       10'h008
`define VPW_T_RX_MIN     10'h022
`define VPW_T_RX_SHORT   10'h060
`define VPW_T_RX_LONG    10'h0a3
`define VPW_T_RX_EOD     10'h0ef
`define VPW_T_IFS        10'h12c
`define VPW_T_NOM_SHORT  10'h040
`define VPW_T_NOM_LONG   10'h080
`define VPW_T_NOM_SOF    10'h0c8
`define VPW_T_NOM_EOF    10'h118
`define VPW_T_ECHO       10'h03c
`define VPW_T_SAT        10'h3ff

// check sequence
`define VPW_CRC_POLY     8'h1d
`define VPW_CRC_INIT     8'hff
`define VPW_CRC_GOOD     8'hc4

`endif

// ### vpw_pkg.sv
// types shared by the vpw controller modules
package vpw_pkg;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SOF  = 2'b01,
      TX_DATA = 2'b11,
      TX_EOF  = 2'b10
   } vpw_tx_state_type;

   typedef struct packed {
      logic [5:0] cnt_int;
      logic [3:0] cnt_us;
      logic       us_tick;
   } vpw_pre_state_type;

   typedef struct packed {
      logic             rx_s1;
      logic             rx_s2;
      logic             rx_f;
      logic [3:0]       filt_cnt;
      logic [9:0]       rx_t;
      logic             in_frame;
      logic             rx_any;
      logic [2:0]       rx_nbits;
      logic [7:0]       rx_sh;
      logic [7:0]       rx_crc;
      logic [7:0]       rx_data;
      logic             st_be;
      logic             st_crc;
      logic             st_tim;
      logic             st_inc;
      logic             st_noecho;
      logic             st_lost;
      logic             st_rxfull;
      logic [4:0]       cfg;
      logic [7:0]       dly;
      logic [7:0]       tx_hold;
      logic             tx_hold_last;
      logic             tx_hold_full;
      vpw_tx_state_type tx_state;
      logic [7:0]       tx_sh;
      logic [2:0]       tx_bit;
      logic             tx_last;
      logic             tx_crcph;
      logic [7:0]       tx_crc;
      logic             tx_lvl;
      logic [9:0]       tx_t;
      logic             wait_echo;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } vpw_ctl_state_type;

endpackage : vpw_pkg

// ### vpw_prescaler.sv
// clock prescaler: internal protocol clock enable and microsecond tick
`timescale 1ns/10ps
`include "vpw_map.svh"

module vpw_prescaler (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       en,
   input  wire logic [1:0] div_sel,
   output logic            us_tick
);

   vpw_pkg::vpw_pre_state_type s_r;
   vpw_pkg::vpw_pre_state_type s_nxt;
   logic [7:0]                 int_mhz;
   logic [5:0]                 int_div;

   // the internal clock is the same for both pll settings, so only the select matters
   always_comb begin
      case (div_sel)
         2'b00:   int_mhz = `VPW_INT_MHZ0;
         2'b01:   int_mhz = `VPW_INT_MHZ1;
         2'b10:   int_mhz = `VPW_INT_MHZ2;
         default: int_mhz = `VPW_INT_MHZ3;
      endcase
      // 6 mhz divides 200 mhz unevenly, giving 6.06 mhz
      int_div = 6'(`VPW_REF_MHZ / int_mhz);
      s_nxt = s_r;
      s_nxt.us_tick = 1'b0;
      if (!en) begin
         s_nxt.cnt_int = 6'h00;
         s_nxt.cnt_us  = 4'h0;
      end else if (s_r.cnt_int == int_div - 6'h01) begin
         s_nxt.cnt_int = 6'h00;
         if (s_r.cnt_us == 4'(int_mhz - 8'h01)) begin
            s_nxt.cnt_us  = 4'h0;
            s_nxt.us_tick = 1'b1;
         end else begin
            s_nxt.cnt_us = s_r.cnt_us + 4'h1;
         end
      end else begin
         s_nxt.cnt_int = s_r.cnt_int + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign us_tick = s_r.us_tick;

endmodule : vpw_prescaler

// ### vpw_serial_bus_controller.sv
// vpw single-wire link controller: frame engine, symbol timing and apb registers
//
// Contract
// - transmit appends computed check byte as the last byte of every frame (an underrun frame ends without it)
// - receive check residue must be c4; otherwise set bus error at once
// - while sending, an unexpected bus edge means contention against our frame
// - on contention arbitration is lost and the rest of the frame is dropped
// - without contention keep sending until the whole frame is out (a missing echo also ends the frame, with a no echo error)
// - crc, timing, incomplete byte and no echo errors each set bus error
// - filtered pulse shorter than 34 us is a symbol timing error
// - end of data off a byte boundary is an incomplete byte error
// - own edge not echoed within 60 us raises no echo error
// - two-bit divide select picks crystal 8/12/16/20 mhz with pll off
// - pll on: crystal 4/6/8/10 mhz; internal clock 4/6/8/10 mhz
// - receive filter discards pulses of 8 us or shorter
// - symbol valid only when its level lasts at least 34 us
// - symbol timing resynchronises on every incoming leading edge
// - vpw symbols at 10.4 kb/s, encoded and decoded alike
// - one bus transition per symbol, levels alternate
// - decoder classifies by duration between edges and bus level
// - active 0 128 us, active 1 64, passive 0 64, passive 1 128
// - fourfold mode divides every symbol time by four
// - status read clears every bit but bus status
`timescale 1ns/10ps
`include "vpw_map.svh"

module vpw_serial_bus_controller (
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        BUS_RECEIVE_PIN,
   output logic             BUS_TRANSMIT_PIN
);

   vpw_pkg::vpw_ctl_state_type s_r;
   vpw_pkg::vpw_ctl_state_type s_nxt;
   logic                       us_tick;
   logic                       rx_edge;
   logic                       rx_bit_ok;
   logic                       rx_bit;
   logic                       bus_busy;
   logic                       apb_done;
   logic                       tx_bitv;
   logic [9:0]                 tx_dur;
   logic [7:0]                 tx_crc_upd;
   logic [9:0]                 comp;

   // scales a normal-rate time for fourfold mode
   function automatic logic [9:0] scl(input logic [9:0] t, input logic quad);
      scl = quad ? (t >> 2) : t;
   endfunction : scl

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `VPW_CRC_POLY : 8'h00);
   endfunction : crc_step

   vpw_prescaler u_pre (
      .clk     (REF_CLK),
      .rst_b   (RST_B),
      .en      (s_r.cfg[`VPW_CFG_EN]),
      .div_sel (s_r.cfg[`VPW_CFG_DIV_HI:`VPW_CFG_DIV_LO]),
      .us_tick (us_tick)
   );

   always_comb begin
      s_nxt      = s_r;
      rx_edge    = 1'b0;
      rx_bit_ok  = 1'b0;
      rx_bit     = 1'b0;
      bus_busy   = s_r.rx_f || (s_r.rx_t < scl(`VPW_T_IFS, s_r.cfg[`VPW_CFG_QUAD]));
      apb_done   = PSEL && PENABLE && s_r.pready;
      tx_bitv    = s_r.tx_sh[7];
      tx_crc_upd = crc_step(s_r.tx_crc, s_r.tx_sh[7]);
      comp       = 10'(s_r.dly) + scl(`VPW_T_FILT, s_r.cfg[`VPW_CFG_QUAD]) + 10'h001;
      // active level lengths are the inverse of passive ones
      if (s_r.tx_lvl) begin
         tx_dur = tx_bitv ? `VPW_T_NOM_SHORT : `VPW_T_NOM_LONG;
      end else begin
         tx_dur = tx_bitv ? `VPW_T_NOM_LONG : `VPW_T_NOM_SHORT;
      end
      tx_dur = scl(tx_dur, s_r.cfg[`VPW_CFG_QUAD]);

      // apb slave: data captured in setup, side effects at the completing edge
      s_nxt.pready  = PSEL && !PENABLE;
      s_nxt.pslverr = 1'b0;
      if (PSEL && !PENABLE) begin
         s_nxt.prdata = 32'h0000_0000;
         case (PADDR)
            `VPW_OFF_CFG:  s_nxt.prdata = {27'h0, s_r.cfg};
            `VPW_OFF_TX:   s_nxt.prdata = {30'h0, s_r.tx_state != vpw_pkg::TX_IDLE,
                                           s_r.tx_hold_full};
            `VPW_OFF_DLY:  s_nxt.prdata = {24'h0, s_r.dly};
            `VPW_OFF_RX:   s_nxt.prdata = {24'h0, s_r.rx_data};
            `VPW_OFF_STAT: s_nxt.prdata = {24'h0, bus_busy, s_r.st_rxfull, s_r.st_lost,
                                           s_r.st_noecho, s_r.st_inc, s_r.st_tim,
                                           s_r.st_crc, s_r.st_be};
            default:       s_nxt.pslverr = 1'b1;
         endcase
      end
      if (apb_done && PWRITE) begin
         case (PADDR)
            `VPW_OFF_CFG: s_nxt.cfg = PWDATA[4:0];
            `VPW_OFF_DLY: s_nxt.dly = PWDATA[7:0];
            `VPW_OFF_TX: begin
               // a write into a full holding byte is dropped
               if (!s_r.tx_hold_full) begin
                  s_nxt.tx_hold      = PWDATA[7:0];
                  s_nxt.tx_hold_last = PWDATA[`VPW_TX_LAST];
                  s_nxt.tx_hold_full = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (apb_done && !PWRITE) begin
         if (PADDR == `VPW_OFF_RX) begin
            s_nxt.st_rxfull = 1'b0;
         end
         // only bits that were shown are cleared, so nothing set meanwhile is lost
         if (PADDR == `VPW_OFF_STAT) begin
            s_nxt.st_be     = s_r.st_be     & ~s_r.prdata[`VPW_ST_BE];
            s_nxt.st_crc    = s_r.st_crc    & ~s_r.prdata[`VPW_ST_CRC];
            s_nxt.st_tim    = s_r.st_tim    & ~s_r.prdata[`VPW_ST_TIM];
            s_nxt.st_inc    = s_r.st_inc    & ~s_r.prdata[`VPW_ST_INC];
            s_nxt.st_noecho = s_r.st_noecho & ~s_r.prdata[`VPW_ST_NOECHO];
            s_nxt.st_lost   = s_r.st_lost   & ~s_r.prdata[`VPW_ST_LOST];
            s_nxt.st_rxfull = s_r.st_rxfull & ~s_r.prdata[`VPW_ST_RXFULL];
         end
      end

      // receive pin synchroniser and noise filter
      s_nxt.rx_s1 = BUS_RECEIVE_PIN;
      s_nxt.rx_s2 = s_r.rx_s1;
      if (s_r.rx_s2 == s_r.rx_f) begin
         s_nxt.filt_cnt = 4'h0;
      end else if (us_tick) begin
         if (s_r.filt_cnt == 4'(scl(`VPW_T_FILT, s_r.cfg[`VPW_CFG_QUAD]))) begin
            s_nxt.rx_f     = s_r.rx_s2;
            s_nxt.filt_cnt = 4'h0;
            rx_edge        = 1'b1;
         end else begin
            s_nxt.filt_cnt = s_r.filt_cnt + 4'h1;
         end
      end

      // both edges carry the same filter lag, so durations stay true
      if (rx_edge) begin
         s_nxt.rx_t = 10'h000;
      end else if (us_tick && s_r.rx_t != `VPW_T_SAT) begin
         s_nxt.rx_t = s_r.rx_t + 10'h001;
      end

      // symbol decode on each filtered edge
      if (rx_edge) begin
         if (s_r.rx_t < scl(`VPW_T_RX_MIN, s_r.cfg[`VPW_CFG_QUAD])) begin
            s_nxt.st_tim   = 1'b1;
            s_nxt.st_be    = 1'b1;
            s_nxt.in_frame = 1'b0;
         end else if (s_r.rx_f) begin
            if (s_r.rx_t >= scl(`VPW_T_RX_EOD, s_r.cfg[`VPW_CFG_QUAD])) begin
               s_nxt.in_frame = 1'b0;
            end else if (s_r.rx_t >= scl(`VPW_T_RX_LONG, s_r.cfg[`VPW_CFG_QUAD])) begin
               s_nxt.in_frame = 1'b1;
               s_nxt.rx_any   = 1'b0;
               s_nxt.rx_nbits = 3'h0;
               s_nxt.rx_crc   = `VPW_CRC_INIT;
            end else begin
               rx_bit_ok = 1'b1;
               rx_bit    = s_r.rx_t < scl(`VPW_T_RX_SHORT, s_r.cfg[`VPW_CFG_QUAD]);
            end
         end else begin
            rx_bit_ok = 1'b1;
            rx_bit    = s_r.rx_t >= scl(`VPW_T_RX_SHORT, s_r.cfg[`VPW_CFG_QUAD]);
         end
      end
      if (rx_bit_ok && s_r.in_frame) begin
         s_nxt.rx_sh    = {s_r.rx_sh[6:0], rx_bit};
         s_nxt.rx_crc   = crc_step(s_r.rx_crc, rx_bit);
         s_nxt.rx_nbits = s_r.rx_nbits + 3'h1;
         if (s_r.rx_nbits == 3'h7) begin
            s_nxt.rx_data   = {s_r.rx_sh[6:0], rx_bit};
            s_nxt.rx_any    = 1'b1;
            s_nxt.st_rxfull = 1'b1;
         end
      end
      // long passive level closes the frame: end of data
      if (s_r.in_frame && !s_r.rx_f && !rx_edge && us_tick &&
          s_r.rx_t == scl(`VPW_T_RX_LONG, s_r.cfg[`VPW_CFG_QUAD])) begin
         s_nxt.in_frame = 1'b0;
         if (s_r.rx_nbits != 3'h0 || !s_r.rx_any) begin
            s_nxt.st_inc = 1'b1;
            s_nxt.st_be  = 1'b1;
         end else if (s_r.rx_crc != `VPW_CRC_GOOD) begin
            s_nxt.st_crc = 1'b1;
            s_nxt.st_be  = 1'b1;
         end
      end

      // transmit engine
      if (s_r.tx_state != vpw_pkg::TX_IDLE) begin
         if (rx_edge && s_r.wait_echo) begin
            s_nxt.wait_echo = 1'b0;
            s_nxt.tx_t      = comp;
         end else if (us_tick && s_r.tx_t != `VPW_T_SAT) begin
            s_nxt.tx_t = s_r.tx_t + 10'h001;
         end
      end
      case (s_r.tx_state)
         vpw_pkg::TX_IDLE: begin
            if (s_r.cfg[`VPW_CFG_EN] && s_r.tx_hold_full && !bus_busy) begin
               s_nxt.tx_sh        = s_r.tx_hold;
               s_nxt.tx_last      = s_r.tx_hold_last;
               s_nxt.tx_hold_full = 1'b0;
               s_nxt.tx_crc       = `VPW_CRC_INIT;
               s_nxt.tx_crcph     = 1'b0;
               s_nxt.tx_bit       = 3'h0;
               s_nxt.tx_lvl       = 1'b1;
               s_nxt.tx_t         = 10'h000;
               s_nxt.wait_echo    = 1'b1;
               s_nxt.tx_state     = vpw_pkg::TX_SOF;
            end
         end
         vpw_pkg::TX_SOF: begin
            // a symbol is held until its own echo is back, so that a lost echo still
            // reaches the 60 us window when fourfold symbols are shorter than it
            if (!s_r.wait_echo &&
                s_r.tx_t >= scl(`VPW_T_NOM_SOF, s_r.cfg[`VPW_CFG_QUAD])) begin
               s_nxt.tx_lvl    = 1'b0;
               s_nxt.tx_t      = 10'h000;
               s_nxt.wait_echo = 1'b1;
               s_nxt.tx_state  = vpw_pkg::TX_DATA;
            end
         end
         vpw_pkg::TX_DATA: begin
            if (!s_r.wait_echo && s_r.tx_t >= tx_dur) begin
               s_nxt.tx_lvl    = !s_r.tx_lvl;
               s_nxt.tx_t      = 10'h000;
               s_nxt.wait_echo = 1'b1;
               s_nxt.tx_sh     = {s_r.tx_sh[6:0], 1'b0};
               s_nxt.tx_bit    = s_r.tx_bit + 3'h1;
               if (!s_r.tx_crcph) begin
                  s_nxt.tx_crc = tx_crc_upd;
               end
               if (s_r.tx_bit == 3'h7) begin
                  if (s_r.tx_crcph) begin
                     s_nxt.tx_state = vpw_pkg::TX_EOF;
                  end else if (s_r.tx_last) begin
                     s_nxt.tx_sh    = ~tx_crc_upd;
                     s_nxt.tx_crcph = 1'b1;
                  end else if (s_r.tx_hold_full) begin
                     s_nxt.tx_sh        = s_r.tx_hold;
                     s_nxt.tx_last      = s_r.tx_hold_last;
                     s_nxt.tx_hold_full = 1'b0;
                  end else begin
                     // underrun: the frame ends without its check byte, receivers see a crc error
                     s_nxt.tx_state = vpw_pkg::TX_EOF;
                  end
               end
            end
         end
         vpw_pkg::TX_EOF: begin
            if (s_r.tx_t >= scl(`VPW_T_NOM_EOF, s_r.cfg[`VPW_CFG_QUAD])) begin
               s_nxt.tx_state = vpw_pkg::TX_IDLE;
            end
         end
         default: s_nxt.tx_state = vpw_pkg::TX_IDLE;
      endcase
      if (s_r.tx_state != vpw_pkg::TX_IDLE) begin
         if (rx_edge && !s_r.wait_echo) begin
            s_nxt.st_lost   = 1'b1;
            s_nxt.tx_lvl    = 1'b0;
            s_nxt.wait_echo = 1'b0;
            s_nxt.tx_state  = vpw_pkg::TX_IDLE;
         end else if (s_r.wait_echo && !rx_edge && s_r.tx_t >= `VPW_T_ECHO) begin
            s_nxt.st_noecho = 1'b1;
            s_nxt.st_be     = 1'b1;
            s_nxt.tx_lvl    = 1'b0;
            s_nxt.wait_echo = 1'b0;
            s_nxt.tx_state  = vpw_pkg::TX_IDLE;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r          <= '0;
         s_r.cfg      <= `VPW_CFG_RST;
         s_r.dly      <= `VPW_DLY_RST;
         s_r.tx_state <= vpw_pkg::TX_IDLE;
         s_r.rx_t     <= `VPW_T_SAT;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PRDATA           = s_r.prdata;
   assign PREADY           = s_r.pready;
   assign PSLVERR          = s_r.pslverr;
   assign BUS_TRANSMIT_PIN = s_r.tx_lvl;

endmodule : vpw_serial_bus_controller

// ### vpw_properties.sv
// bound checks on the apb port and the bus pins of the vpw controller
`timescale 1ns/10ps
`include "vpw_map.svh"

module vpw_properties (
   input wire logic        REF_CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        BUS_RECEIVE_PIN,
   input wire logic        BUS_TRANSMIT_PIN
);
   logic        tx_q_r;
   logic [15:0] hi_cnt_r;
   logic [15:0] mis_cnt_r;
   logic [15:0] stay_cnt_r;
   logic        mapped;

   assign mapped = PADDR inside {`VPW_OFF_CFG, `VPW_OFF_TX, `VPW_OFF_DLY, `VPW_OFF_RX,
                                 `VPW_OFF_STAT};

   // counters instead of long repetitions, which the tools would unroll
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_q_r     <= 1'b0;
         hi_cnt_r   <= 16'h0;
         mis_cnt_r  <= 16'h0;
         stay_cnt_r <= 16'hffff;
      end else begin
         tx_q_r     <= BUS_TRANSMIT_PIN;
         hi_cnt_r   <= BUS_TRANSMIT_PIN ? hi_cnt_r + 16'h1 : 16'h0;
         mis_cnt_r  <= (BUS_TRANSMIT_PIN && !BUS_RECEIVE_PIN) ? mis_cnt_r + 16'h1 : 16'h0;
         stay_cnt_r <= (BUS_TRANSMIT_PIN != tx_q_r) ? 16'h0 :
                       stay_cnt_r + {15'h0, stay_cnt_r != 16'hffff};
      end
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   setup_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready in the cycle after setup");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held past the access edge");
   ready_phase_a: assert property (PREADY |-> PENABLE && $past(PSEL && !PENABLE))
      else $error("ready outside an access phase");
   err_map_a: assert property (PREADY |-> PSLVERR == !mapped)
      else $error("slave error does not match the address map");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("slave error without ready");
   unmapped_zero_a: assert property (PREADY && !PWRITE && !mapped |-> PRDATA == 32'h0)
      else $error("unmapped read returned data");
   rdata_width_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
      else $error("unused read bits not zero");
   echo_wait_a: assert property (mis_cnt_r <= 16'h2fa8)
      else $error("active drive kept without echo past the window");
   sym_min_a: assert property (BUS_TRANSMIT_PIN != tx_q_r |-> stay_cnt_r >= 16'h0af0)
      else $error("transmit symbol shorter than the shortest symbol");
   active_max_a: assert property (hi_cnt_r <= 16'ha1b8)
      else $error("active drive longer than a start symbol");

   cover property (PREADY && PSLVERR);
   cover property ($rose(BUS_TRANSMIT_PIN));
   cover property (PREADY && !PWRITE && PADDR == `VPW_OFF_STAT && PRDATA[`VPW_ST_LOST]);
endmodule : vpw_properties

bind vpw_serial_bus_controller vpw_properties u_vpw_properties (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .BUS_RECEIVE_PIN(BUS_RECEIVE_PIN), .BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN));

// ### vpw_xcvr.sv
// transceiver model: delayed echo of our pin, wired with a foreign node's drive
`timescale 1ns/10ps

module vpw_xcvr #(
   parameter real ECHO_NS = 2000.0
) (
   input  wire logic tx_pin,
   output logic      rx_pin
);
   logic echo_on;
   logic echo_q;
   logic frn;

   initial begin
      echo_on = 1'b1;
      echo_q  = 1'b0;
      frn     = 1'b0;
   end

   // transport delay keeps every edge, as the loop through a real transceiver does
   always @(tx_pin) begin
      echo_q <= #(ECHO_NS) tx_pin & echo_on;
   end

   // active level dominates the wire
   assign rx_pin = echo_q | frn;

   task automatic pulse(input real us);
      frn = 1'b1;
      #(us * 1000.0);
      frn = 1'b0;
   endtask : pulse
endmodule : vpw_xcvr

// ### tb_top.sv
// self-checking bench for the vpw controller: apb tasks, frame decode, error cases
`timescale 1ns/10ps
`include "vpw_map.svh"

module tb_top;
   logic        ref_clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_pin;
   logic        tx_pin;
   logic [31:0] d;
   logic        e;
   logic        lv;
   logic [15:0] got;
   logic [15:0] ex;
   real         dur;
   int          n_mismatch;
   int          checks;

   vpw_serial_bus_controller u_vpw_serial_bus_controller (.REF_CLK(ref_clk), .RST_B(rst_b),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_RECEIVE_PIN(rx_pin),
      .BUS_TRANSMIT_PIN(tx_pin));
   vpw_xcvr u_vpw_xcvr (.tx_pin(tx_pin), .rx_pin(rx_pin));

   always #2.5 ref_clk = ~ref_clk;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
      checks++;
      if (act !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, act);
      end
   endtask : chk

   task automatic chk_us(input string nm, input real nom, input real act);
      checks++;
      if (act < nom - 2.0 || act > nom + 2.0) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0.1f us seen %0.1f us", nm, nom, act);
      end
   endtask : chk_us

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle limit here: only the watchdog ends a wait
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      chk("pready_wait", 32'h1, 32'(n));
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, d & m);
   endtask : rchk

   // one symbol: level held and its length in microseconds
   task automatic sym();
      realtime t0;
      lv = tx_pin;
      t0 = $realtime;
      @(tx_pin);
      dur = ($realtime - t0) / 1000.0;
   endtask : sym

   function automatic logic [7:0] crc8(input logic [7:0] b);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h1d : 8'h00);
      return ~c;
   endfunction : crc8

   task automatic wrap_up();
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      // the scenarios take about 1 ms of bus time
      #1500000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      n_mismatch = 0;
      checks = 0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      rchk("cfg_rst", `VPW_OFF_CFG, 32'hffffffff, 32'h0);
      rchk("dly_rst", `VPW_OFF_DLY, 32'hffffffff, 32'h0);
      rchk("tx_rst", `VPW_OFF_TX, 32'hffffffff, 32'h0);
      rchk("stat_rst", `VPW_OFF_STAT, 32'hffffffff, 32'h0);
      apb(1'b1, 8'h14, 32'h1f);
      chk("wr_unmapped_err", 32'h1, {31'h0, e});
      rchk("rd_unmapped", 8'h14, 32'hffffffff, 32'h0);
      chk("rd_unmapped_err", 32'h1, {31'h0, e});
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `VPW_OFF_CFG, 32'h4 | 32'(i));
         rchk("cfg_div", `VPW_OFF_CFG, 32'hffffffff, 32'h4 | 32'(i));
      end
      apb(1'b1, `VPW_OFF_DLY, 32'hffffff02);
      rchk("dly", `VPW_OFF_DLY, 32'hffffffff, 32'h2);
      apb(1'b1, `VPW_OFF_CFG, 32'h1b);
      // fourfold mode keeps the run short; symbol and filter times below are quartered, the 60 us echo window is not
      apb(1'b1, `VPW_OFF_TX, 32'h155);
      wait (tx_pin === 1'b1);
      sym();
      chk("sof_lvl", 32'h1, {31'h0, lv});
      chk_us("sof_len", 50.0, dur);
      ex = {8'h55, crc8(8'h55)};
      got = 16'h0;
      for (int i = 0; i < 16; i++) begin
         sym();
         chk("sym_lvl", 32'(i % 2), {31'h0, lv});
         chk_us("sym_len", (ex[15 - i] ^ lv) ? 32.0 : 16.0, dur);
         got = {got[14:0], (dur > 24.0) ^ lv};
      end
      chk("frame", {16'h0, ex}, {16'h0, got});
      #50000;
      rchk("stat_good", `VPW_OFF_STAT, 32'h3f, 32'h0);
      rchk("stat_clear", `VPW_OFF_STAT, 32'h7f, 32'h0);
      apb(1'b1, `VPW_OFF_TX, 32'h100);
      wait (tx_pin === 1'b1);
      @(negedge tx_pin);
      // past our own filtered echo, before our next toggle
      #8000;
      u_vpw_xcvr.pulse(30.0);
      chk("pin_lost", 32'h0, {31'h0, tx_pin});
      rchk("stat_lost", `VPW_OFF_STAT, 32'h20, 32'h20);
      u_vpw_xcvr.echo_on = 1'b0;
      apb(1'b1, `VPW_OFF_TX, 32'h1ff);
      wait (tx_pin === 1'b1);
      #70000;
      chk("pin_noecho", 32'h0, {31'h0, tx_pin});
      rchk("stat_noecho", `VPW_OFF_STAT, 32'h11, 32'h11);
      u_vpw_xcvr.echo_on = 1'b1;
      #10000;
      apb(1'b0, `VPW_OFF_STAT, 32'h0);
      u_vpw_xcvr.pulse(0.8);
      #10000;
      rchk("stat_noise", `VPW_OFF_STAT, 32'h3f, 32'h0);
      u_vpw_xcvr.pulse(5.0);
      #10000;
      rchk("stat_timing", `VPW_OFF_STAT, 32'h05, 32'h05);
      #10000;
      u_vpw_xcvr.pulse(50.0);
      #16000;
      u_vpw_xcvr.pulse(16.0);
      #50000;
      rchk("stat_incomplete", `VPW_OFF_STAT, 32'h09, 32'h09);
      wrap_up();
   end
endmodule : tb_top
